//--- design/aci_cfg.svh
`ifndef ACI_CFG_SVH
`define ACI_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define ACI_IDX_CTRL 16'hffd0
`define ACI_IDX_PIN_EN 16'hffd1
`define ACI_IDX_RES_LO 16'hffd2
`define ACI_IDX_RES_HI 16'hffd3
`define ACI_IDX_IRQ_MASK 16'hffe7
`define ACI_IDX_IRQ_FLAG 16'hfff7

// Field positions inside the conversion control register.
`define ACI_CTRL_CHAN_LO 0
`define ACI_CTRL_CHAN_HI 1
`define ACI_CTRL_CLK_SEL 2
`define ACI_CTRL_START 3

// Field positions of the interrupt mask and flag registers.
`define ACI_IRQ_BIT 0

// Reset values.
`define ACI_RST_CHAN 2'h0
`define ACI_RST_CLK_SEL 1'h0
`define ACI_RST_PIN_EN 4'h0
`define ACI_RST_MASK 1'h0
`define ACI_RST_FLAG 1'h0

// Conversion length in selected conversion clock cycles.
`define ACI_CONV_CYCLES 16

// Register data width and the bus lane that carries it.
`define ACI_REG_W 4
`define ACI_LANE 0

`endif

//--- design/aci_pkg.sv
package aci_pkg;

    typedef enum logic {
        ACI_IDLE,
        ACI_CONVERT
    } aci_state_t;

    typedef struct packed {
        logic clk_sel;
        logic [1:0] chan;
    } aci_ctrl_t;

    typedef struct packed {
        logic [3:0] pin_en;
        logic [1:0] chan;
        logic clk_sel;
        logic clk_en;
        logic clk_tick;
        logic start;
    } aci_core_t;

endpackage

//--- design/aci_sync_edge.sv
`timescale 1ns/10ps

module aci_sync_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic rise_o
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // Two flip-flops bring the oscillator level into the bus clock domain.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    // The edge detector looks only at the second stage.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= sync_ff;
        end
    end

    assign rise_o = sync_ff & ~last_ff;

endmodule

//--- design/aci_adc_ctrl.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "aci_cfg.svh"

// Function
// - Pin enable bit 1 makes pin analog.
// - Clock select 1 fast, 0 slow, resets 0.
// - Two-bit channel field picks input 0-3.
// - Start write begins conversion, then loads result.
// - Start write 0 ignored, start reads zero.
// - Result low nibble first address, high next.
// - Result registers not cleared by reset.
// - Mask bit enables completion interrupt, resets 0.
// - Flag set on completion, readable, resets 0.
// - Flag sets regardless of mask bit.
// - Writing 1 clears flag, 0 ignored.
// - Unused mask and flag bits read zero.
// - Start gates selected clock to converter core.
// - Flag and mask raise interrupt request.

module aci_adc_ctrl
    import aci_pkg::*;
#(
    parameter int CONV_CYCLES = `ACI_CONV_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [17:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic SLOW_OSC_I,
    input wire logic FAST_OSC_I,
    input wire logic [7:0] CORE_RESULT_I,
    output logic [3:0] ANALOG_PIN_ENABLE_O,
    output logic [1:0] CHANNEL_SELECT_O,
    output logic CONV_CLOCK_SELECT_O,
    output logic CONV_CLOCK_ENABLE_O,
    output logic CONV_CLOCK_TICK_O,
    output logic CONV_START_O,
    output logic CONV_BUSY_O,
    output logic IRQ_O
);

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

    aci_ctrl_t ctrl_ff;
    aci_state_t state_ff;
    aci_state_t nxt_state;
    aci_core_t core_ff;
    logic [3:0] pin_en_ff;
    logic mask_ff;
    logic flag_ff;
    logic [3:0] result_lo_ff;
    logic [3:0] result_hi_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic half_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic slow_rise;
    logic fast_rise;
    logic sel_tick;
    logic bus_req;
    logic wr_lane;
    logic [`ACI_REG_W-1:0] wdat;
    logic wr_ctrl;
    logic wr_pin_en;
    logic wr_mask;
    logic wr_flag;
    logic start_req;
    logic conv_done;
    logic [31:0] rd_mux;
    logic conv_active;
    logic conv_tick;
    logic cnt_last;
    logic wr_start;
    logic flag_clr;
    logic rd_req;
    logic [3:0] nxt_pin_en;
    logic [1:0] nxt_chan;
    logic nxt_clk_sel;

    // Oscillator inputs come from outside the bus clock and are synchronised.
    aci_sync_edge u_slow_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(SLOW_OSC_I),
        .rise_o(slow_rise)
    );

    aci_sync_edge u_fast_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(FAST_OSC_I),
        .rise_o(fast_rise)
    );

    // Bus request decode; a request is taken once, in the cycle before ACK.
    assign bus_req = CYC_I & STB_I & ~ack_ff;
    assign wr_lane = bus_req & WE_I & SEL_I[`ACI_LANE];
    assign wdat = DAT_I[`ACI_REG_W-1:0];
    assign rd_req = bus_req & ~WE_I;

    // Write strobes; the result registers and unmapped indices take no write.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_pin_en = 1'b0;
        wr_mask = 1'b0;
        wr_flag = 1'b0;
        if (wr_lane) begin
            unique case (ADR_I)
                `ACI_IDX_CTRL: begin
                    wr_ctrl = 1'b1;
                end
                `ACI_IDX_PIN_EN: begin
                    wr_pin_en = 1'b1;
                end
                `ACI_IDX_IRQ_MASK: begin
                    wr_mask = 1'b1;
                end
                `ACI_IDX_IRQ_FLAG: begin
                    wr_flag = 1'b1;
                end
                `ACI_IDX_RES_LO, `ACI_IDX_RES_HI: begin
                    wr_ctrl = 1'b0;
                end
                default: begin
                    wr_ctrl = 1'b0;
                end
            endcase
        end
    end

    // Only a written 1 starts; a 0 or a start during a conversion does nothing.
    assign conv_active = (state_ff == ACI_CONVERT);
    assign wr_start = wr_ctrl & wdat[`ACI_CTRL_START];
    assign start_req = wr_start & ~conv_active;

    // The fast source runs at half its rate, so every second edge is used.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            half_ff <= 1'b0;
        end else if (fast_rise) begin
            half_ff <= ~half_ff;
        end
    end

    // Clock selector output, as single-cycle edges in the bus clock domain.
    always_comb begin
        if (ctrl_ff.clk_sel) begin
            sel_tick = fast_rise & half_ff;
        end else begin
            sel_tick = slow_rise;
        end
    end

    assign conv_tick = conv_active & sel_tick;
    assign cnt_last = (cnt_ff == CNT_LAST);
    assign conv_done = conv_tick & cnt_last;

    // Values the control registers take at this edge, forwarded to the core at once.
    assign nxt_pin_en = wr_pin_en ? wdat : pin_en_ff;
    assign nxt_chan = wr_ctrl ? wdat[`ACI_CTRL_CHAN_HI:`ACI_CTRL_CHAN_LO] : ctrl_ff.chan;
    assign nxt_clk_sel = wr_ctrl ? wdat[`ACI_CTRL_CLK_SEL] : ctrl_ff.clk_sel;

    // Control register: clock select and channel are stored, start is not.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_ff.clk_sel <= `ACI_RST_CLK_SEL;
            ctrl_ff.chan <= `ACI_RST_CHAN;
        end else if (wr_ctrl) begin
            ctrl_ff.clk_sel <= wdat[`ACI_CTRL_CLK_SEL];
            ctrl_ff.chan <= wdat[`ACI_CTRL_CHAN_HI:`ACI_CTRL_CHAN_LO];
        end
    end

    // Analog pin enables switch the shared port pins to analog use.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_en_ff <= `ACI_RST_PIN_EN;
        end else if (wr_pin_en) begin
            pin_en_ff <= wdat;
        end
    end

    // Interrupt mask; only bit 0 is stored.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mask_ff <= `ACI_RST_MASK;
        end else if (wr_mask) begin
            mask_ff <= wdat[`ACI_IRQ_BIT];
        end
    end

    assign flag_clr = wr_flag & wdat[`ACI_IRQ_BIT];

    // Completion flag; a completion in the clearing cycle wins.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag_ff <= `ACI_RST_FLAG;
        end else if (conv_done) begin
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end

    // Conversion sequencer.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ACI_IDLE: begin
                if (start_req) begin
                    nxt_state = ACI_CONVERT;
                end
            end
            ACI_CONVERT: begin
                if (conv_done) begin
                    nxt_state = ACI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= ACI_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counts the selected conversion clock cycles of one conversion.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_ff <= '0;
        end else if (start_req) begin
            cnt_ff <= '0;
        end else if (conv_tick) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // The result nibbles hold no reset value; both load at each completion.
    always_ff @(posedge CLK_I) begin
        if (conv_done) begin
            result_lo_ff <= CORE_RESULT_I[3:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (conv_done) begin
            result_hi_ff <= CORE_RESULT_I[7:4];
        end
    end

    // Signals toward the analog core, all from flip-flops.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            core_ff <= '0;
        end else begin
            core_ff.pin_en <= nxt_pin_en;
            core_ff.chan <= nxt_chan;
            core_ff.clk_sel <= nxt_clk_sel;
            core_ff.clk_en <= (nxt_state == ACI_CONVERT);
            core_ff.clk_tick <= conv_tick;
            core_ff.start <= start_req;
        end
    end

    // Read multiplexer; unused bits and unmapped addresses read zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ADR_I)
            `ACI_IDX_CTRL: begin
                rd_mux[`ACI_CTRL_CLK_SEL] = ctrl_ff.clk_sel;
                rd_mux[`ACI_CTRL_CHAN_HI:`ACI_CTRL_CHAN_LO] = ctrl_ff.chan;
                rd_mux[`ACI_CTRL_START] = 1'b0;
            end
            `ACI_IDX_PIN_EN: begin
                rd_mux[`ACI_REG_W-1:0] = pin_en_ff;
            end
            `ACI_IDX_RES_LO: begin
                rd_mux[`ACI_REG_W-1:0] = result_lo_ff;
            end
            `ACI_IDX_RES_HI: begin
                rd_mux[`ACI_REG_W-1:0] = result_hi_ff;
            end
            `ACI_IDX_IRQ_MASK: begin
                rd_mux[`ACI_IRQ_BIT] = mask_ff;
            end
            `ACI_IDX_IRQ_FLAG: begin
                rd_mux[`ACI_IRQ_BIT] = flag_ff;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Bus answer: every request is acknowledged one cycle after it is taken.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dat_ff <= 32'h0000_0000;
        end else if (rd_req) begin
            dat_ff <= rd_mux;
        end else if (bus_req) begin
            dat_ff <= 32'h0000_0000;
        end
    end

    assign DAT_O = dat_ff;
    assign ACK_O = ack_ff;

    assign ANALOG_PIN_ENABLE_O = core_ff.pin_en;
    assign CHANNEL_SELECT_O = core_ff.chan;
    assign CONV_CLOCK_SELECT_O = core_ff.clk_sel;
    assign CONV_CLOCK_ENABLE_O = core_ff.clk_en;
    assign CONV_CLOCK_TICK_O = core_ff.clk_tick;
    assign CONV_START_O = core_ff.start;
    assign CONV_BUSY_O = conv_active;

    // Interrupt request toward the CPU, gated by the mask.
    assign IRQ_O = flag_ff & mask_ff;

endmodule

//--- bench/aci_adc_ctrl_chk.sv
`timescale 1ns/10ps
module aci_adc_ctrl_chk (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [17:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic [3:0] ANALOG_PIN_ENABLE_O,
    input wire logic [1:0] CHANNEL_SELECT_O,
    input wire logic CONV_CLOCK_SELECT_O,
    input wire logic CONV_CLOCK_ENABLE_O,
    input wire logic CONV_START_O,
    input wire logic CONV_BUSY_O,
    input wire logic IRQ_O
);
    logic cw;
    logic go;
    assign cw = CYC_I && STB_I && !ACK_O && WE_I && SEL_I[0];
    assign go = cw && ADR_I == 16'hffd0 && DAT_I[3];
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    start_cause_a: assert property (CONV_START_O |-> $past(go) && !$past(CONV_BUSY_O))
        else $error("start without request");
    no_start_a: assert property (cw && ADR_I == 16'hffd0 && !DAT_I[3] |=> !CONV_START_O)
        else $error("start on zero write");
    mask_off_a: assert property (cw && ADR_I == 16'hffe7 && !DAT_I[0] |=> !IRQ_O)
        else $error("irq while masked");
    clk_end_a: assert property ($fell(CONV_BUSY_O) |-> !CONV_CLOCK_ENABLE_O && $past(CONV_CLOCK_ENABLE_O))
        else $error("clock gate wrong at end");
    clk_follow_a: assert property (CONV_CLOCK_ENABLE_O == CONV_BUSY_O)
        else $error("clock gate differs from busy");
    ctrl_store_a: assert property (cw && ADR_I == 16'hffd0 |=>
        CHANNEL_SELECT_O == $past(DAT_I[1:0]) && CONV_CLOCK_SELECT_O == $past(DAT_I[2]))
        else $error("control fields not stored");
    pin_store_a: assert property (cw && ADR_I == 16'hffd1 |=> ANALOG_PIN_ENABLE_O == $past(DAT_I[3:0]))
        else $error("pin enables not stored");
    unused_bits_a: assert property (ACK_O && !$past(WE_I) &&
        ($past(ADR_I) == 16'hffe7 || $past(ADR_I) == 16'hfff7) |-> DAT_O[31:1] == '0)
        else $error("unused bits not zero");
    start_gate_a: assert property (CONV_START_O |-> CONV_BUSY_O && CONV_CLOCK_ENABLE_O)
        else $error("start without clock gate");
    cover property (CONV_START_O);
    cover property ($fell(CONV_BUSY_O));
    cover property (IRQ_O);
endmodule

bind aci_adc_ctrl aci_adc_ctrl_chk chk (.CLK_I, .RST_N_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I,
    .DAT_O, .ACK_O, .ANALOG_PIN_ENABLE_O, .CHANNEL_SELECT_O, .CONV_CLOCK_SELECT_O,
    .CONV_CLOCK_ENABLE_O, .CONV_START_O, .CONV_BUSY_O, .IRQ_O);

//--- bench/aci_osc_model.sv
`timescale 1ns/10ps
module aci_osc_model (
    input wire logic [7:0] val_i,
    output logic slow_o,
    output logic fast_o,
    output logic [7:0] result_o
);
    initial slow_o = 1'b0;
    initial fast_o = 1'b0;
    // Both oscillators run free, so a clock is always there to convert with.
    always #43 slow_o = ~slow_o;
    always #17 fast_o = ~fast_o;
    assign result_o = val_i;
endmodule

//--- bench/aci_adc_ctrl_bench.sv
`timescale 1ns/10ps
module aci_adc_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = '0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = '0;
    logic [7:0] val = 8'h00;
    logic [31:0] rdat;
    logic [31:0] d_o;
    logic [7:0] res;
    logic [3:0] pins;
    logic [1:0] chan;
    logic slow, fast, ack, start, busy, irq, ck_sel, ck_en, tick;
    int bad_count = 0;
    int num_checks = 0;
    int starts = 0;
    int ticks = 0;
    always #5 clk = ~clk;
    aci_osc_model osc (.val_i(val), .slow_o(slow), .fast_o(fast), .result_o(res));
    aci_adc_ctrl #(.CONV_CYCLES(3)) uut (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(d_o), .ACK_O(ack),
        .SLOW_OSC_I(slow), .FAST_OSC_I(fast), .CORE_RESULT_I(res), .ANALOG_PIN_ENABLE_O(pins),
        .CHANNEL_SELECT_O(chan), .CONV_CLOCK_SELECT_O(ck_sel), .CONV_CLOCK_ENABLE_O(ck_en),
        .CONV_CLOCK_TICK_O(tick), .CONV_START_O(start), .CONV_BUSY_O(busy), .IRQ_O(irq));
    always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
    always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {28'h000_0000, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 100);
        rdat = d_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 100) bad_count++;
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'h0);
        chk(rdat, exp);
    endtask
    task automatic conv(input logic [3:0] c, input logic [7:0] v);
        int n;
        n = 0;
        val <= v;
        wr(16'hffd0, c);
        chk(busy, 1);
        chk(ck_en, 1);
        wr(16'hffd0, c);
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) bad_count++;
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hffd0, 0);
        rd(16'hffd1, 0);
        rd(16'hffe7, 0);
        rd(16'hfff7, 0);
        wr(16'hffd1, 4'h5);
        chk(pins, 5);
        wr(16'hffd4, 4'hf);
        rd(16'hffd1, 5);
        for (int c = 0; c < 4; c++) begin
            wr(16'hffd0, c[3:0]);
            chk(chan, c);
            rd(16'hffd0, c);
        end
        wr(16'hffe7, 4'hf);
        rd(16'hffe7, 1);
        conv(4'ha, 8'h3c);
        rd(16'hfff7, 1);
        chk(irq, 1);
        rd(16'hffd2, 4'hc);
        rd(16'hffd3, 4'h3);
        chk(ticks, 3);
        rd(16'hffd0, 4'h2);
        wr(16'hfff7, 4'he);
        rd(16'hfff7, 1);
        wr(16'hfff7, 4'h1);
        rd(16'hfff7, 0);
        wr(16'hffe7, 4'h0);
        conv(4'hc, 8'hd7);
        chk(ck_sel, 1);
        rd(16'hfff7, 1);
        chk(irq, 0);
        rd(16'hffd2, 4'h7);
        rd(16'hffd3, 4'hd);
        chk(starts, 2);
        chk(ticks, 6);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hfff7, 0);
        chk(ck_sel, 0);
        rd(16'hffe7, 0);
        chk(irq, 0);
        complete_run;
    end
endmodule
